// >>> logic/mdc_pkg.sv
// Package for the motor drive output conditioning block: register map, fields, resets, types
// How it works
// - Mask enable blocks generator, uses mask data
// - Masked channel drives its mask data level
// - Brake wins: low sides on, highs off
// - Protect forces free run or brake
// - Dead time delays every rising edge
// - Falling edges pass with no delay
// - Dead time clock divides by 1,2,4,8
// - Dead time only when enable bit set
// - Dead time is count plus one ticks
// - Pair both on turns pair off
// - One means transistor on by default
// - Per output polarity invert bit
// - Gate pins high impedance after reset
// - Hall source software, pins or comparators
// - Filter enable bypasses or uses filter
// - Filter accepts change after count samples
// - Delay select low clears both buffers
// - Delay select high drives timer run
// - Software mask only in mask mode one
// - Pair masked high both forces zero
package mdc_pkg;
  // Register offsets (8-bit registers on a byte address bus)
  localparam logic [3:0] ADDR_MASK_EN = 4'h0;
  localparam logic [3:0] ADDR_MASK_VAL = 4'h1;
  localparam logic [3:0] ADDR_DEAD_TIME = 4'h2;
  localparam logic [3:0] ADDR_POLARITY = 4'h3;
  localparam logic [3:0] ADDR_MODE_CTRL = 4'h4;
  localparam logic [3:0] ADDR_HALL_CTRL = 4'h5;
  localparam logic [3:0] ADDR_HALL_SW = 4'h6;
  localparam logic [3:0] ADDR_HALL_FILT = 4'h7;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_FILT_CNT = 8'h01;
  // Dead time register fields
  localparam int DT_CNT_LSB = 0;
  localparam int DT_EN_BIT = 5;
  localparam int DT_DIV_LSB = 6;
  // Mode control fields
  localparam int MC_BRAKE_BIT = 0;
  localparam int MC_PROT_SEL_BIT = 1;
  localparam int MC_MASK_MODE_BIT = 2;
  localparam int MC_OUT_EN_BIT = 3;
  // Hall control fields
  localparam int HC_DEC_EN_BIT = 0;
  localparam int HC_SRC_MODE_BIT = 1;
  localparam int HC_PIN_SEL_BIT = 2;
  localparam int HC_FILT_EN_BIT = 3;
  localparam int HC_DELAY_SEL_BIT = 4;
  localparam int HC_TIMER_LSB = 5;
  // Width of the largest dead-time divider count
  localparam int DIV_W = 3;

  // Six drive channels: bit 0 a high .. bit 5 c low; even bits are high sides
  typedef logic [5:0] mdc_drive_t;
  localparam mdc_drive_t HIGH_SIDES = 6'h15;
  localparam mdc_drive_t LOW_SIDES = 6'h2a;

  // Decoded register write
  typedef struct packed {
    logic we;
    logic [3:0] addr;
    logic [7:0] data;
  } mdc_wr_s;

  // Dead-time channel states
  typedef enum logic [1:0] {
    DT_LOW = 2'b00,
    DT_WAIT = 2'b01,
    DT_HIGH = 2'b10
  } mdc_dt_e;
endpackage : mdc_pkg

// >>> logic/mdc_top.sv
// Output conditioning for six gate drives plus hall input front end
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module mdc_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Drive sources
  input wire logic [5:0] i_pwm_drive,
  input wire logic [5:0] i_hw_mask_drive,
  input wire logic i_protect,
  // Hall sources
  input wire logic [2:0] i_hall_pins,
  input wire logic [2:0] i_hall_cmp,
  input wire logic i_filter_sample,
  // Gate outputs, two signals per pin
  output logic [5:0] o_gate,
  output logic [5:0] o_gate_oe,
  // Hall path outputs
  output logic [2:0] o_hall_decoded_in,
  output logic o_hall_delay_active,
  output logic [2:0] o_delay_buf1,
  output logic [2:0] o_delay_buf2,
  output logic [2:0] o_timer_run_bit,
  output logic o_hall_decoder_en
);
  // Software registers
  logic [5:0] chan_mask_en_q;
  logic [5:0] chan_mask_val_q;
  logic [7:0] dead_time_q;
  logic [5:0] polarity_q;
  logic [3:0] mode_q;
  logic [6:0] hall_ctrl_q;
  logic [2:0] hall_sw_q;
  logic [4:0] hall_filter_count_q;
  mdc_pkg::mdc_wr_s wr;

  assign wr = '{we: i_wr, addr: i_addr, data: i_wdata};

  // Register writes; gates stay released until software enables the drivers
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      chan_mask_en_q <= mdc_pkg::RST_ZERO[5:0];
      chan_mask_val_q <= mdc_pkg::RST_ZERO[5:0];
      dead_time_q <= mdc_pkg::RST_ZERO;
      polarity_q <= mdc_pkg::RST_ZERO[5:0];
      mode_q <= mdc_pkg::RST_ZERO[3:0];
      hall_ctrl_q <= mdc_pkg::RST_ZERO[6:0];
      hall_sw_q <= mdc_pkg::RST_ZERO[2:0];
      hall_filter_count_q <= mdc_pkg::RST_FILT_CNT[4:0];
    end else if (wr.we) begin
      case (wr.addr)
        mdc_pkg::ADDR_MASK_EN: chan_mask_en_q <= wr.data[5:0];
        mdc_pkg::ADDR_MASK_VAL: chan_mask_val_q <= wr.data[5:0];
        mdc_pkg::ADDR_DEAD_TIME: dead_time_q <= wr.data;
        mdc_pkg::ADDR_POLARITY: polarity_q <= wr.data[5:0];
        mdc_pkg::ADDR_MODE_CTRL: mode_q <= wr.data[3:0];
        mdc_pkg::ADDR_HALL_CTRL: hall_ctrl_q <= wr.data[6:0];
        mdc_pkg::ADDR_HALL_SW: hall_sw_q <= wr.data[2:0];
        mdc_pkg::ADDR_HALL_FILT: hall_filter_count_q <= wr.data[4:0];
        default: ;
      endcase
    end
  end

  // Field aliases
  logic brake_en;
  logic protect_output_sel;
  logic mask_mode_sel;
  logic out_en;
  logic deadtime_en;
  logic [1:0] deadtime_clk_div_sel;
  logic [4:0] deadtime_cnt;
  logic hall_decode_src_mode;
  logic hall_pin_sel;
  logic hall_filter_en;
  logic hall_delay_sel;
  logic [1:0] delay_timer_sel;

  assign brake_en = mode_q[mdc_pkg::MC_BRAKE_BIT];
  assign protect_output_sel = mode_q[mdc_pkg::MC_PROT_SEL_BIT];
  assign mask_mode_sel = mode_q[mdc_pkg::MC_MASK_MODE_BIT];
  assign out_en = mode_q[mdc_pkg::MC_OUT_EN_BIT];
  assign deadtime_en = dead_time_q[mdc_pkg::DT_EN_BIT];
  assign deadtime_clk_div_sel = dead_time_q[mdc_pkg::DT_DIV_LSB +: 2];
  assign deadtime_cnt = dead_time_q[mdc_pkg::DT_CNT_LSB +: 5];
  assign hall_decode_src_mode = hall_ctrl_q[mdc_pkg::HC_SRC_MODE_BIT];
  assign hall_pin_sel = hall_ctrl_q[mdc_pkg::HC_PIN_SEL_BIT];
  assign hall_filter_en = hall_ctrl_q[mdc_pkg::HC_FILT_EN_BIT];
  assign hall_delay_sel = hall_ctrl_q[mdc_pkg::HC_DELAY_SEL_BIT];
  assign delay_timer_sel = hall_ctrl_q[mdc_pkg::HC_TIMER_LSB +: 2];

  // Stage 1: masking
  logic [5:0] masked;
  always_comb begin
    if (!mask_mode_sel) begin
      masked = i_hw_mask_drive;
    end else begin
      masked = (i_pwm_drive & ~chan_mask_en_q) | (chan_mask_val_q & chan_mask_en_q);
      // both masked high forces pair low
      for (int p = 0; p < 3; p++) begin
        if ((&chan_mask_en_q[2*p +: 2]) && (&chan_mask_val_q[2*p +: 2])) begin
          masked[2*p +: 2] = 2'b00;
        end
      end
    end
  end

  // Stage 2: brake and protect overrides, brake first
  // Protect is a level: outputs return to the mask result once it drops
  logic [5:0] overridden;
  always_comb begin
    if (brake_en) begin
      overridden = mdc_pkg::LOW_SIDES;
    end else if (i_protect) begin
      overridden = protect_output_sel ? mdc_pkg::LOW_SIDES : 6'h00;
    end else begin
      overridden = masked;
    end
  end

  // Dead-time tick divider; the tick counts the dead-time clock periods
  logic [mdc_pkg::DIV_W-1:0] div_q;
  logic dt_tick;
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end
  // Ticks come from a free-running count, so a rise may come up to one tick period short of count plus one ticks
  always_comb begin
    case (deadtime_clk_div_sel)
      2'b00: dt_tick = 1'b1;
      2'b01: dt_tick = div_q[0];
      2'b10: dt_tick = &div_q[1:0];
      default: dt_tick = &div_q;
    endcase
  end

  // Stage 3: dead time per channel
  logic [5:0] delayed;
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_dt
      mdc_pkg::mdc_dt_e st_q;
      logic [5:0] cnt_q;
      // restart on rise, drop short requests
      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          st_q <= mdc_pkg::DT_LOW;
          cnt_q <= 6'h00;
        end else begin
          case (st_q)
            mdc_pkg::DT_LOW: begin
              if (overridden[g]) begin
                st_q <= mdc_pkg::DT_WAIT;
                cnt_q <= 6'h00;
              end
            end
            mdc_pkg::DT_WAIT: begin
              // A request that falls before the count ends is dropped
              if (!overridden[g]) begin
                st_q <= mdc_pkg::DT_LOW;
              end else if (dt_tick && (cnt_q == {1'b0, deadtime_cnt})) begin
                st_q <= mdc_pkg::DT_HIGH;
              end else if (dt_tick) begin
                cnt_q <= cnt_q + 6'h01;
              end
            end
            mdc_pkg::DT_HIGH: begin
              if (!overridden[g]) begin
                st_q <= mdc_pkg::DT_LOW;
              end
            end
            default: st_q <= mdc_pkg::DT_LOW;
          endcase
        end
      end
      assign delayed[g] = deadtime_en ? (overridden[g] && (st_q == mdc_pkg::DT_HIGH)) : overridden[g];
    end
  endgenerate

  // Stage 4: pair overlap guard then polarity, registered toward the pins
  // Guard sits after dead time, so no pair overlap reaches the pins
  logic [5:0] guarded;
  always_comb begin
    guarded = delayed;
    for (int p = 0; p < 3; p++) begin
      if (&delayed[2*p +: 2]) begin
        guarded[2*p +: 2] = 2'b00;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_gate <= 6'h00;
    end else begin
      // one is on, invert bits flip
      o_gate <= guarded ^ polarity_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_gate_oe <= 6'h00;
    end else begin
      o_gate_oe <= {6{out_en}};
    end
  end

  // Hall source selection
  logic [2:0] hall_hw;
  logic [2:0] hall_filt_q;
  logic [2:0] hall_hw_sel;
  assign hall_hw = hall_pin_sel ? i_hall_cmp : i_hall_pins;

  // Noise filter: each input needs a run of equal samples before it is accepted
  generate
    for (g = 0; g < 3; g++) begin : g_nf
      logic [4:0] run_q;
      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          run_q <= 5'h00;
          hall_filt_q[g] <= 1'b0;
        end else if (i_filter_sample) begin
          // Any sample that agrees with the accepted level restarts the run
          if (hall_hw[g] == hall_filt_q[g]) begin
            run_q <= 5'h00;
          end else if (run_q + 5'h01 >= hall_filter_count_q) begin
            hall_filt_q[g] <= hall_hw[g];
            run_q <= 5'h00;
          end else begin
            run_q <= run_q + 5'h01;
          end
        end
      end
    end
  endgenerate

  assign hall_hw_sel = hall_filter_en ? hall_filt_q : hall_hw;

  // Registered hall input to the decoder
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_hall_decoded_in <= 3'h0;
    end else begin
      o_hall_decoded_in <= hall_decode_src_mode ? hall_hw_sel : hall_sw_q;
    end
  end

  // Hall delay buffers, cleared while bypassed
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_delay_buf1 <= 3'h0;
      o_delay_buf2 <= 3'h0;
    end else if (!hall_delay_sel) begin
      o_delay_buf1 <= 3'h0;
      o_delay_buf2 <= 3'h0;
    end else begin
      o_delay_buf1 <= o_hall_decoded_in;
      o_delay_buf2 <= o_delay_buf1;
    end
  end

  // Timer run control; code 11 picks no timer
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_timer_run_bit <= 3'h0;
    // hardware owns chosen timer run bit
    end else if (hall_delay_sel && delay_timer_sel != 2'b11) begin
      o_timer_run_bit <= 3'h1 << delay_timer_sel;
    end else begin
      o_timer_run_bit <= 3'h0;
    end
  end

  assign o_hall_delay_active = hall_ctrl_q[mdc_pkg::HC_DELAY_SEL_BIT];
  assign o_hall_decoder_en = hall_ctrl_q[mdc_pkg::HC_DEC_EN_BIT];

  // Read data one cycle after the strobe, zero otherwise and for unmapped offsets
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || !i_rd) begin
      o_rdata <= 8'h00;
    end else begin
      case (i_addr)
        mdc_pkg::ADDR_MASK_EN: o_rdata <= {2'b00, chan_mask_en_q};
        mdc_pkg::ADDR_MASK_VAL: o_rdata <= {2'b00, chan_mask_val_q};
        mdc_pkg::ADDR_DEAD_TIME: o_rdata <= dead_time_q;
        mdc_pkg::ADDR_POLARITY: o_rdata <= {2'b00, polarity_q};
        mdc_pkg::ADDR_MODE_CTRL: o_rdata <= {4'h0, mode_q};
        mdc_pkg::ADDR_HALL_CTRL: o_rdata <= {1'b0, hall_ctrl_q};
        mdc_pkg::ADDR_HALL_SW: o_rdata <= {5'h00, hall_sw_q};
        mdc_pkg::ADDR_HALL_FILT: o_rdata <= {3'h0, hall_filter_count_q};
        mdc_pkg::ADDR_STATUS: o_rdata <= {2'b00, hall_filt_q, o_hall_decoded_in};
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  // Assertions
  a_brake_output: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (brake_en && !deadtime_en) |=> (o_gate ^ $past(polarity_q)) == mdc_pkg::LOW_SIDES) else $error("brake output wrong");
  a_protect_free: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (!brake_en && i_protect && !protect_output_sel && !deadtime_en) |=> (o_gate ^ $past(polarity_q)) == 6'h00)
    else $error("protect free run wrong");
  a_pair_guard: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ##1 !(&(o_gate[1:0] ^ $past(polarity_q[1:0])))) else $error("pair a both on");
  a_fall_nodelay: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (!overridden[0]) |=> !(o_gate[0] ^ $past(polarity_q[0]))) else $error("fall delayed");
  a_rise_delay: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (deadtime_en && $rose(overridden[0])) |=> !(o_gate[0] ^ $past(polarity_q[0]))) else $error("rise not delayed");
  a_buf_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !hall_delay_sel |=> (o_delay_buf1 == 3'h0 && o_delay_buf2 == 3'h0)) else $error("buffers not cleared");
  a_sw_source: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !hall_decode_src_mode |=> o_hall_decoded_in == $past(hall_sw_q)) else $error("software hall not used");
  a_timer_run: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !hall_delay_sel |=> o_timer_run_bit == 3'h0) else $error("timer run while bypassed");

  // Drive path checks at the pins, dead time off so the result lands one cycle later
  a_protect_brake: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (!brake_en && i_protect && protect_output_sel && !deadtime_en) |=>
    (o_gate ^ $past(polarity_q)) == mdc_pkg::LOW_SIDES)
    else $error("protect brake wrong");
  a_mask_pair: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (mask_mode_sel && !brake_en && !i_protect && !deadtime_en && (&chan_mask_en_q[3:2]) && !(&chan_mask_val_q[3:2]))
    |=> (o_gate[3:2] ^ $past(polarity_q[3:2])) == $past(chan_mask_val_q[3:2]))
    else $error("mask data not driven");
  a_hw_mask: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (!mask_mode_sel && !brake_en && !i_protect && !deadtime_en && !(&i_hw_mask_drive[1:0]))
    |=> (o_gate[1:0] ^ $past(polarity_q[1:0])) == $past(i_hw_mask_drive[1:0]))
    else $error("hardware mask path not used");
  a_pol_invert: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (mask_mode_sel && !brake_en && !i_protect && !deadtime_en && chan_mask_en_q == 6'h00 && i_pwm_drive == 6'h01)
    |=> o_gate == ($past(polarity_q) ^ 6'h01))
    else $error("polarity not applied");
  a_gate_release: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !out_en |=> o_gate_oe == 6'h00) else $error("gate driven while released");

  // Hall path checks
  a_filter_bypass: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (hall_decode_src_mode && !hall_filter_en) |=> o_hall_decoded_in == $past(hall_hw))
    else $error("filter not bypassed");
  a_timer_pick: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (hall_delay_sel && delay_timer_sel == 2'b10) |=> o_timer_run_bit == 3'h4)
    else $error("wrong timer run bit");
  c_brake: cover property (@(posedge i_clk) disable iff (!i_rst_b) brake_en ##1 !brake_en);
  c_dead_time: cover property (@(posedge i_clk) disable iff (!i_rst_b) deadtime_en && $rose(delayed[0]));
  c_filter: cover property (@(posedge i_clk) disable iff (!i_rst_b) hall_filter_en && $changed(hall_filt_q));
  c_protect: cover property (@(posedge i_clk) disable iff (!i_rst_b) i_protect && !brake_en && protect_output_sel);
  c_timer_run: cover property (@(posedge i_clk) disable iff (!i_rst_b) hall_delay_sel && (|o_timer_run_bit));
endmodule : mdc_top

// >>> sim/mdc_gate_driver_model.sv
// Gate driver model: resolves gate pins and flags pair shorts
`timescale 1ns/100ps
module mdc_gate_driver_model (
  // Gate pins from the block
  input wire logic [5:0] i_gate,
  input wire logic [5:0] i_gate_oe,
  // Levels seen at the driver inputs
  output logic [5:0] o_pin_level,
  output logic [2:0] o_pair_short
);
  // Released pins pulled down
  // Pull-downs keep a floating gate input off, so hi-Z reads as 0
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      o_pin_level[i] = i_gate_oe[i] ? i_gate[i] : 1'b0;
    end
  end
  // One switches transistor on
  // Both sides of a pair on means a short across the supply
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      o_pair_short[p] = o_pin_level[2 * p] & o_pin_level[2 * p + 1];
    end
  end
endmodule : mdc_gate_driver_model

// >>> sim/mdc_top_tb_top.sv
// Self-checking bench for the motor drive output conditioning block
`timescale 1ns/100ps
module mdc_top_tb_top;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [5:0] i_pwm_drive = 6'h00;
  logic [5:0] i_hw_mask_drive = 6'h00;
  logic i_protect = 1'b0;
  logic [2:0] i_hall_pins = 3'h0;
  logic [2:0] i_hall_cmp = 3'h0;
  logic i_filter_sample = 1'b0;
  logic [7:0] o_rdata;
  logic [5:0] o_gate;
  logic [5:0] o_gate_oe;
  logic [5:0] pin_level;
  logic [2:0] pair_short;
  logic [2:0] hall_in;
  logic dly_act;
  logic [2:0] buf1;
  logic [2:0] buf2;
  logic [2:0] run_bit;
  logic dec_en;
  logic seen;
  int miscompares = 0;
  int checked = 0;

  // 250 MHz system clock
  always #2 i_clk = ~i_clk;

  mdc_top mdc_top_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_pwm_drive(i_pwm_drive), .i_hw_mask_drive(i_hw_mask_drive),
    .i_protect(i_protect), .i_hall_pins(i_hall_pins), .i_hall_cmp(i_hall_cmp),
    .i_filter_sample(i_filter_sample), .o_gate(o_gate), .o_gate_oe(o_gate_oe), .o_hall_decoded_in(hall_in),
    .o_hall_delay_active(dly_act), .o_delay_buf1(buf1), .o_delay_buf2(buf2), .o_timer_run_bit(run_bit),
    .o_hall_decoder_en(dec_en));

  mdc_gate_driver_model mdc_gate_driver_model_inst (.i_gate(o_gate), .i_gate_oe(o_gate_oe),
    .o_pin_level(pin_level), .o_pair_short(pair_short));

  // Compare tasks, one per kind of result
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t register got %h want %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_vec(input logic [5:0] got, input logic [5:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t output got %h want %h", $time, got, exp);
    end
  endtask : chk_vec

  task automatic chk_win(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("CHECK FAILED t=%0t delay %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_win

  // Register port: one-cycle strobes, read data only in the following cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk_reg(o_rdata, exp);
  endtask : rd

  // Apply drive inputs, let the pipeline settle, then look at the pins
  task automatic step(input logic [5:0] pwm, input logic [5:0] hw, input logic [5:0] exp);
    @(posedge i_clk);
    i_pwm_drive <= pwm;
    i_hw_mask_drive <= hw;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    chk_vec(pin_level, exp);
  endtask : step

  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask : settle

  // Time a rising edge through dead time, then its falling edge
  task automatic dt_meas(input logic [1:0] div, input logic [4:0] cnt);
    int ticks;
    int len;
    ticks = (int'(cnt) + 1) * (1 << div);
    wr(mdc_pkg::ADDR_DEAD_TIME, {div, 1'b1, cnt});
    step(6'h00, 6'h00, 6'h00);
    @(posedge i_clk);
    i_pwm_drive <= 6'h01;
    len = 0;
    do begin
      @(negedge i_clk);
      len++;
    end while (o_gate[0] !== 1'b1 && len < 400);
    chk_win(len, ticks - (1 << div) + 2, ticks + 3);
    @(posedge i_clk);
    i_pwm_drive <= 6'h00;
    settle(1);
    chk_vec(pin_level, 6'h00);
  endtask : dt_meas

  task automatic end_sim;
    $display("Counts: checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #40000;
    miscompares++;
    end_sim();
  end

  initial begin
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    chk_vec(o_gate_oe, 6'h00);
    chk_vec(o_gate, 6'h00);
    @(posedge i_clk);
    i_rst_b <= 1'b1;
    // Reset values and unused bits
    for (int a = 0; a < 8; a++) begin
      rd(4'(a), (a == 7) ? mdc_pkg::RST_FILT_CNT : mdc_pkg::RST_ZERO);
    end
    chk_vec(pin_level, 6'h00);
    wr(mdc_pkg::ADDR_MASK_EN, 8'hff);
    rd(mdc_pkg::ADDR_MASK_EN, 8'h3f);
    wr(mdc_pkg::ADDR_POLARITY, 8'hff);
    rd(mdc_pkg::ADDR_POLARITY, 8'h3f);
    wr(mdc_pkg::ADDR_DEAD_TIME, 8'hff);
    rd(mdc_pkg::ADDR_DEAD_TIME, 8'hff);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    wr(mdc_pkg::ADDR_POLARITY, 8'h00);
    wr(mdc_pkg::ADDR_MASK_EN, 8'h00);
    // Dead time programmed but disabled: no delay
    wr(mdc_pkg::ADDR_DEAD_TIME, 8'hdf);
    wr(mdc_pkg::ADDR_MODE_CTRL, 8'h0c);
    step(6'h05, 6'h00, 6'h05);
    chk_vec(o_gate_oe, 6'h3f);
    step(6'h03, 6'h00, 6'h00);
    chk_vec({3'h0, pair_short}, 6'h00);
    // Software masking, including a pair forced off
    wr(mdc_pkg::ADDR_MASK_EN, 8'h3f);
    wr(mdc_pkg::ADDR_MASK_VAL, 8'h06);
    step(6'h31, 6'h00, 6'h06);
    wr(mdc_pkg::ADDR_MASK_VAL, 8'h03);
    step(6'h00, 6'h00, 6'h00);
    wr(mdc_pkg::ADDR_MASK_EN, 8'h0c);
    wr(mdc_pkg::ADDR_MASK_VAL, 8'h08);
    step(6'h05, 6'h00, 6'h09);
    // Hardware mask path ignores mask registers
    wr(mdc_pkg::ADDR_MODE_CTRL, 8'h08);
    step(6'h05, 6'h22, 6'h22);
    // Brake beats masking; protect picks free run or brake
    wr(mdc_pkg::ADDR_MODE_CTRL, 8'h0f);
    i_protect <= 1'b1;
    step(6'h15, 6'h15, 6'h2a);
    wr(mdc_pkg::ADDR_MODE_CTRL, 8'h0c);
    step(6'h15, 6'h15, 6'h00);
    wr(mdc_pkg::ADDR_MODE_CTRL, 8'h0e);
    step(6'h15, 6'h15, 6'h2a);
    @(posedge i_clk);
    i_protect <= 1'b0;
    // Polarity applied after the guard
    wr(mdc_pkg::ADDR_MODE_CTRL, 8'h0c);
    wr(mdc_pkg::ADDR_MASK_EN, 8'h00);
    wr(mdc_pkg::ADDR_POLARITY, 8'h3f);
    step(6'h01, 6'h00, 6'h3e);
    step(6'h03, 6'h00, 6'h3f);
    wr(mdc_pkg::ADDR_POLARITY, 8'h00);
    // Every divider code, longest count on divide by one
    for (int d = 0; d < 4; d++) begin
      dt_meas(2'(d), (d == 0) ? 5'h1f : 5'h02);
    end
    // Pulse shorter than the dead time is dropped
    seen = 1'b0;
    @(posedge i_clk);
    i_pwm_drive <= 6'h01;
    repeat (2) @(posedge i_clk);
    i_pwm_drive <= 6'h00;
    repeat (12) begin
      @(negedge i_clk);
      seen = seen | o_gate[0];
    end
    chk_vec({5'h00, seen}, 6'h00);
    // Hall source selection
    @(posedge i_clk);
    i_hall_pins <= 3'h3;
    i_hall_cmp <= 3'h6;
    wr(mdc_pkg::ADDR_HALL_SW, 8'h05);
    wr(mdc_pkg::ADDR_HALL_CTRL, 8'h00);
    settle(3);
    chk_vec({3'h0, hall_in}, 6'h05);
    wr(mdc_pkg::ADDR_HALL_CTRL, 8'h02);
    settle(3);
    chk_vec({3'h0, hall_in}, 6'h03);
    wr(mdc_pkg::ADDR_HALL_CTRL, 8'h06);
    settle(3);
    chk_vec({3'h0, hall_in}, 6'h06);
    // Filter holds without samples, follows after enough of them
    wr(mdc_pkg::ADDR_HALL_FILT, 8'h03);
    wr(mdc_pkg::ADDR_HALL_CTRL, 8'h0a);
    i_filter_sample <= 1'b1;
    settle(12);
    chk_vec({3'h0, hall_in}, 6'h03);
    @(posedge i_clk);
    i_filter_sample <= 1'b0;
    i_hall_pins <= 3'h5;
    settle(12);
    chk_vec({3'h0, hall_in}, 6'h03);
    @(posedge i_clk);
    i_filter_sample <= 1'b1;
    settle(1);
    chk_vec({3'h0, hall_in}, 6'h03);
    settle(12);
    chk_vec({3'h0, hall_in}, 6'h05);
    @(posedge i_clk);
    i_filter_sample <= 1'b0;
    wr(mdc_pkg::ADDR_HALL_CTRL, 8'h02);
    i_hall_pins <= 3'h2;
    settle(3);
    chk_vec({3'h0, hall_in}, 6'h02);
    chk_vec({buf1, buf2}, 6'h00);
    // Delay set up before the decoder is enabled, no timer chosen
    wr(mdc_pkg::ADDR_HALL_CTRL, 8'h72);
    wr(mdc_pkg::ADDR_HALL_CTRL, 8'h73);
    settle(3);
    chk_vec({2'h0, dly_act, dec_en, 2'h0}, 6'h0c);
    chk_vec({3'h0, run_bit}, 6'h00);
    // Each real timer code owns its run bit; buffers shift the decoder input
    wr(mdc_pkg::ADDR_HALL_CTRL, 8'h12);
    settle(3);
    chk_vec({3'h0, run_bit}, 6'h01);
    chk_vec({buf1, buf2}, 6'h12);
    wr(mdc_pkg::ADDR_HALL_CTRL, 8'h32);
    settle(3);
    chk_vec({3'h0, run_bit}, 6'h02);
    wr(mdc_pkg::ADDR_HALL_CTRL, 8'h52);
    settle(3);
    chk_vec({3'h0, run_bit}, 6'h04);
    wr(mdc_pkg::ADDR_HALL_CTRL, 8'h03);
    settle(3);
    chk_vec({dly_act, buf1, 2'h0}, 6'h00);
    chk_vec({buf2, run_bit}, 6'h00);
    // Status shows the filtered level and the decoder input
    rd(mdc_pkg::ADDR_STATUS, 8'h2a);
    end_sim();
  end
endmodule : mdc_top_tb_top
